// ==== design/ebi_defines.svh ====
`ifndef EBI_DEFINES_SVH
`define EBI_DEFINES_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define EBI_CLK_MHZ      40
// Least width of a read or store strobe, in ns
`define EBI_STRB_MIN_NS  75
// Same in clock cycles, rounded up
`define EBI_STRB_CYC     ((`EBI_STRB_MIN_NS * `EBI_CLK_MHZ + 999) / 1000)
// ----------------------------------------
// Clock output selection
// ----------------------------------------
`define EBI_CKSEL_DIV8   2'h0
`define EBI_CKSEL_DIV32  2'h1
`define EBI_CKSEL_SUB    2'h2
// Divider bits giving main clock / 8 and / 32
`define EBI_DIV8_BIT     2
`define EBI_DIV32_BIT    4
// ----------------------------------------
// Address fields
// ----------------------------------------
// Space select taken from the top two address bits
`define EBI_SPACE_LSB    18
`endif

// ==== design/ebi_pkg.sv ====
package ebi_pkg;
	// Bus cycle sequencer states
	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_addr = 3'b001,
		st_strb = 3'b010,
		st_done = 3'b011,
		st_hold = 3'b100
	} ebi_state_t;
endpackage : ebi_pkg

// ==== design/ebi_top.sv ====
`timescale 1ns/1ps
`include "ebi_defines.svh"
// What this block does
// - 8-bit mux: low pins carry address, then data
// - 16-bit mux: A0 dedicated, A1-A7 share D0-D6
// - 16-bit mux: A8 shares D7; A9-A15 plain
// - Separate bus drives A8-A15 on own pins
// - Drive A16-A19 on dedicated pins
// - One of four active-low space selects per access
// - Software picks split or single store strobes
// - Split: even writes low strobe, odd high; 8-bit bus uses low only
// - Single: store strobe, read strobe, odd byte enable
// - Hold request low keeps hold, ack low
// - Address latch strobe marks address on pins
// - Ready input low stretches the access
// - Clock pin: main/8, main/32 or sub clock
module ebi_top (
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	input  wire logic        mux_en_i,           // Multiplexed address/data bus
	input  wire logic        strobe_single_i,    // 1: store strobe plus byte enable
	input  wire logic        single_chip_i,      // Enables the clock output pin
	input  wire logic [1:0]  clk_sel_i,          // Clock output source
	input  wire logic        bus_width_8_i,      // Width pin, high for 8-bit
	input  wire logic        hold_n_i,           // Bus release request pin
	input  wire logic        rdy_n_i,            // Ready pin, low stretches
	input  wire logic        sub_osc_input_i,    // Sub oscillator pin
	input  wire logic        req_i,              // Access request
	input  wire logic        wr_i,               // 1: write
	input  wire logic        word_i,             // 1: 16-bit access
	input  wire logic [19:0] addr_i,             // Byte address
	input  wire logic [15:0] wdata_i,            // Lane-aligned write data
	output logic             done_o,             // Access finished pulse
	output logic [15:0]      rdata_o,            // Lane-aligned read data
	output logic [7:0]       alo_o,              // Low address / muxed pins
	output logic [7:0]       alo_oe_o,
	input  wire logic [7:0]  alo_i,
	output logic [7:0]       amid_o,             // Middle address pins
	output logic [7:0]       amid_oe_o,
	input  wire logic [7:0]  amid_i,
	output logic [15:0]      dbus_o,             // Separate data pins
	output logic [15:0]      dbus_oe_o,
	input  wire logic [15:0] dbus_i,
	output logic [3:0]       ahi_o,              // High address pins
	output logic [3:0]       space_select_n_o,
	output logic             low_byte_store_strobe_n_o,
	output logic             high_byte_store_strobe_n_o,
	output logic             rd_n_o,
	output logic             ctl_oe_o,           // Enable for address/strobe pins
	output logic             ale_o,
	output logic             bclk_o,
	output logic             bus_release_ack_n_o,
	output logic             clock_out_pin_o
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	ebi_pkg::ebi_state_t state_r, state_nxt;   // Sequencer
	logic [1:0]  cnt_r;                         // Strobe width count
	logic [19:0] addr_r;                        // Latched request
	logic [15:0] wdata_r;
	logic        wr_r, word_r;
	logic [19:0] a_nxt;                         // Request seen by pins
	logic [15:0] wd_nxt;
	logic        wr_nxt, word_nxt;
	logic [1:0]  ln;                            // Byte lanes {hi, lo}
	logic        strb, addr_ph;                 // Next phase decode
	logic [1:0]  bus8_m, hold_m, rdy_m, sub_m;  // Synchroniser stages {second, first}
	logic        bus8_s, hold_n_s, rdy_n_s, sub_s;
	logic [31:0] din_m, din_s;                  // Data pin synchroniser
	logic [4:0]  div_r;                         // Clock output divider

	// Byte lanes used by an access
	function automatic logic [1:0] lanes(input logic a0, input logic wd, input logic b8);
		lanes = {a0 | (wd & ~b8), ~a0 | (wd & ~b8)};
	endfunction : lanes

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Two stages for every pin input
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bus8_m <= 2'h0;
			hold_m <= 2'h3;
			rdy_m  <= 2'h3;
			sub_m  <= 2'h0;
		end else begin
			bus8_m <= {bus8_m[0], bus_width_8_i};
			hold_m <= {hold_m[0], hold_n_i};
			rdy_m  <= {rdy_m[0], rdy_n_i};
			sub_m  <= {sub_m[0], sub_osc_input_i};
		end
	end
	assign bus8_s   = bus8_m[1];
	assign hold_n_s = hold_m[1];
	assign rdy_n_s  = rdy_m[1];
	assign sub_s    = sub_m[1];

	// Data pins for reads
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			din_m <= 32'h0;
			din_s <= 32'h0;
		end else begin
			din_m <= {dbus_i, amid_i, alo_i};
			din_s <= din_m;
		end
	end

	// ----------------------------------------
	// Bus cycle sequencer
	// ----------------------------------------
	// Next state; hold wins over a new request
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ebi_pkg::st_idle: begin
				if (!hold_n_s)
					state_nxt = ebi_pkg::st_hold;
				else if (req_i)
					state_nxt = ebi_pkg::st_addr;
			end
			ebi_pkg::st_addr: state_nxt = ebi_pkg::st_strb;
			ebi_pkg::st_strb: begin
				if (cnt_r == 2'h0 && rdy_n_s)
					state_nxt = ebi_pkg::st_done;
			end
			ebi_pkg::st_done: state_nxt = ebi_pkg::st_idle;
			ebi_pkg::st_hold: begin
				if (hold_n_s)
					state_nxt = ebi_pkg::st_idle;
			end
			default: state_nxt = ebi_pkg::st_idle;
		endcase
	end

	// State and strobe width counter
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= ebi_pkg::st_idle;
			cnt_r   <= 2'h0;
		end else begin
			state_r <= state_nxt;
			if (state_nxt == ebi_pkg::st_strb && state_r != ebi_pkg::st_strb)
				cnt_r <= 2'(`EBI_STRB_CYC - 1);
			else if (cnt_r != 2'h0)
				cnt_r <= cnt_r - 2'h1;
		end
	end

	// Request capture when taken
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			addr_r  <= 20'h0;
			wdata_r <= 16'h0;
			wr_r    <= 1'b0;
			word_r  <= 1'b0;
		end else begin
			addr_r  <= a_nxt;
			wdata_r <= wd_nxt;
			wr_r    <= wr_nxt;
			word_r  <= word_nxt;
		end
	end

	// Request as the pins will carry it
	always_comb begin
		a_nxt    = addr_r;
		wd_nxt   = wdata_r;
		wr_nxt   = wr_r;
		word_nxt = word_r;
		if (state_r == ebi_pkg::st_idle && state_nxt == ebi_pkg::st_addr) begin
			a_nxt    = addr_i;
			wd_nxt   = wdata_i;
			wr_nxt   = wr_i;
			word_nxt = word_i;
		end
	end
	assign strb    = (state_nxt == ebi_pkg::st_strb);
	assign addr_ph = (state_nxt == ebi_pkg::st_addr) | strb;
	assign ln      = lanes(a_nxt[0], word_nxt, bus8_s);

	// ----------------------------------------
	// Address and data pins
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			alo_o     <= 8'h0;
			alo_oe_o  <= 8'h0;
			amid_o    <= 8'h0;
			amid_oe_o <= 8'h0;
			dbus_o    <= 16'h0;
			dbus_oe_o <= 16'h0;
			ahi_o     <= 4'h0;
			ctl_oe_o  <= 1'b0;
		end else if (state_nxt == ebi_pkg::st_hold) begin
			alo_oe_o  <= 8'h0;
			amid_oe_o <= 8'h0;
			dbus_oe_o <= 16'h0;
			ctl_oe_o  <= 1'b0;
		end else begin
			ctl_oe_o  <= 1'b1;
			alo_oe_o  <= 8'hff;
			amid_oe_o <= 8'hff;
			dbus_oe_o <= 16'h0;
			ahi_o     <= a_nxt[19:16];
			alo_o     <= a_nxt[7:0];
			amid_o    <= a_nxt[15:8];
			if (strb && mux_en_i && bus8_s) begin
				// Low pins turn to data D0-D7
				alo_o    <= wd_nxt[7:0];
				alo_oe_o <= {8{wr_nxt}};
			end else if (strb && mux_en_i) begin
				// A0 stays; A1-A7 and A8 turn to data
				alo_o     <= {wd_nxt[6:0], a_nxt[0]};
				alo_oe_o  <= {{7{wr_nxt}}, 1'b1};
				amid_o    <= {a_nxt[15:9], wd_nxt[7]};
				amid_oe_o <= {7'h7f, wr_nxt};
				dbus_o    <= {wd_nxt[15:8], 8'h0};
				dbus_oe_o <= {{8{wr_nxt}}, 8'h0};
			end else if (strb) begin
				// Separate bus: data on its own pins
				dbus_o    <= wd_nxt;
				dbus_oe_o <= {{8{wr_nxt & ~bus8_s}}, {8{wr_nxt}}};
			end
		end
	end

	// ----------------------------------------
	// Strobes and selects
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			low_byte_store_strobe_n_o  <= 1'b1;
			high_byte_store_strobe_n_o <= 1'b1;
			rd_n_o                     <= 1'b1;
			ale_o                      <= 1'b0;
			space_select_n_o           <= 4'hf;
		end else begin
			ale_o  <= (state_nxt == ebi_pkg::st_addr);
			rd_n_o <= ~(strb & ~wr_nxt);
			space_select_n_o <= addr_ph ?
				~(4'h1 << a_nxt[`EBI_SPACE_LSB +: 2]) : 4'hf;
			if (strobe_single_i) begin
				// Store strobe plus upper byte enable
				low_byte_store_strobe_n_o  <= ~(strb & wr_nxt);
				high_byte_store_strobe_n_o <= ~(addr_ph & ln[1]);
			end else begin
				// Split strobes per byte lane
				low_byte_store_strobe_n_o  <= ~(strb & wr_nxt & (ln[0] | bus8_s));
				high_byte_store_strobe_n_o <= ~(strb & wr_nxt & ln[1] & ~bus8_s);
			end
		end
	end

	// ----------------------------------------
	// Completion and read data
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			done_o  <= 1'b0;
			rdata_o <= 16'h0;
		end else begin
			done_o <= (state_r == ebi_pkg::st_strb) && (state_nxt == ebi_pkg::st_done);
			if (state_r == ebi_pkg::st_strb && state_nxt == ebi_pkg::st_done && !wr_r) begin
				if (mux_en_i && bus8_s)
					rdata_o <= {8'h0, din_s[7:0]};
				else if (mux_en_i)
					rdata_o <= {din_s[31:24], din_s[8], din_s[7:1]};
				else if (bus8_s)
					rdata_o <= {8'h0, din_s[23:16]};
				else
					rdata_o <= din_s[31:16];
			end
		end
	end

	// ----------------------------------------
	// Hold acknowledge, bus clock, clock pin
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bus_release_ack_n_o <= 1'b1;
			bclk_o              <= 1'b0;
			div_r               <= 5'h0;
			clock_out_pin_o     <= 1'b0;
		end else begin
			bus_release_ack_n_o <= (state_nxt != ebi_pkg::st_hold);
			bclk_o              <= ~bclk_o;
			div_r               <= div_r + 5'h1;
			// Selected clock only in single-chip mode
			if (!single_chip_i)
				clock_out_pin_o <= 1'b0;
			else if (clk_sel_i == `EBI_CKSEL_DIV8)
				clock_out_pin_o <= div_r[`EBI_DIV8_BIT];
			else if (clk_sel_i == `EBI_CKSEL_DIV32)
				clock_out_pin_o <= div_r[`EBI_DIV32_BIT];
			else if (clk_sel_i == `EBI_CKSEL_SUB)
				clock_out_pin_o <= sub_s;
			else
				clock_out_pin_o <= 1'b0;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	hold_enter_a: assert property (state_r == ebi_pkg::st_idle && !hold_n_s
		|=> !bus_release_ack_n_o && !ctl_oe_o) else $error("hold not entered");
	hold_stay_a: assert property (!bus_release_ack_n_o && !hold_n_s
		|=> !bus_release_ack_n_o) else $error("hold left early");
	hold_float_a: assert property (!bus_release_ack_n_o |-> alo_oe_o == 8'h0
		&& amid_oe_o == 8'h0 && dbus_oe_o == 16'h0) else $error("bus driven in hold");
	ale_addr_a: assert property (ale_o |-> alo_o == addr_r[7:0]
		&& alo_oe_o == 8'hff ##1 !ale_o) else $error("latch strobe without address");
	wait_stretch_a: assert property (state_r == ebi_pkg::st_strb && !rdy_n_s
		|=> state_r == ebi_pkg::st_strb && done_o == 1'b0) else $error("wait ignored");
	mux8_data_a: assert property (state_r == ebi_pkg::st_strb && $past(strb) && wr_r
		&& mux_en_i && bus8_s && $stable(mux_en_i) && $stable(bus8_s)
		|-> alo_o == wdata_r[7:0]) else $error("mux8 data wrong");
	mux16_a0_a: assert property (state_r == ebi_pkg::st_strb && mux_en_i && !bus8_s
		&& $stable(mux_en_i) && $stable(bus8_s)
		|-> alo_o[0] == addr_r[0] && amid_o[7:1] == addr_r[15:9]) else $error("A0 or A9-15 lost");
	hi_addr_a: assert property (ale_o |-> ahi_o == addr_r[19:16]
		&& space_select_n_o == ~(4'h1 << addr_r[19:18])) else $error("high address or select");
	split_even_a: assert property (!strobe_single_i && !bus8_s
		&& $stable(strobe_single_i) && state_r == ebi_pkg::st_strb && wr_r && !word_r && !addr_r[0]
		|-> !low_byte_store_strobe_n_o && high_byte_store_strobe_n_o) else $error("split strobe");
	single_ube_a: assert property (strobe_single_i && $stable(strobe_single_i)
		&& state_r == ebi_pkg::st_strb && addr_r[0] |-> !high_byte_store_strobe_n_o
		&& rd_n_o == wr_r) else $error("byte enable or read strobe");
	strb_width_a: assert property ($fell(rd_n_o) |-> (!rd_n_o)[*3]) else $error("read strobe short");
	clk_div8_a: assert property (single_chip_i && clk_sel_i == `EBI_CKSEL_DIV8
		|=> clock_out_pin_o == $past(div_r[2])) else $error("clock pin wrong");

	write_cv: cover property (state_r == ebi_pkg::st_strb && wr_r ##1 done_o);
	read_wait_cv: cover property (state_r == ebi_pkg::st_strb && !rdy_n_s && !wr_r ##[1:20] done_o);
	hold_cv: cover property ($fell(bus_release_ack_n_o) ##[1:20] $rose(bus_release_ack_n_o));
endmodule : ebi_top

// ==== sim/ebi_mem.sv ====
`timescale 1ns/1ps
// External memory seen through the bus pins
module ebi_mem (
	input  wire logic        mclk_i,
	input  wire logic        mux_i,     // Multiplexed bus in use
	input  wire logic        b8_i,      // 8-bit data bus
	input  wire logic        single_i,  // Store strobe plus byte enable
	input  wire logic        slow_i,    // Answer with wait cycles
	input  wire logic        ale_i,
	input  wire logic [19:0] a_i,       // Address pins as driven
	input  wire logic [15:0] dq_i,      // Data pins as driven
	input  wire logic [7:0]  aoe_i,
	input  wire logic [7:0]  moe_i,
	input  wire logic [15:0] doe_i,
	input  wire logic        lo_n_i,
	input  wire logic        hi_n_i,
	input  wire logic        rd_n_i,
	output logic      [7:0]  lp_o,      // Low pin levels
	output logic      [7:0]  mp_o,      // Middle pin levels
	output logic      [15:0] dp_o,      // Data pin levels
	output logic             rdy_n_o
);
	logic [7:0]  mem [4096];            // Byte store, aliased
	logic [19:0] adr;                   // Latched address
	logic [7:0]  pat = 8'h00;           // Changes every cycle off the bus
	logic [2:0]  cnt = 3'h0;            // Strobe cycles seen
	logic [15:0] rw, wd, din;
	logic        act, lo, hi;
	assign act = !rd_n_i || !lo_n_i || (!single_i && !hi_n_i);
	assign lo = !lo_n_i && (b8_i || !single_i || !adr[0]);
	assign hi = !b8_i && !hi_n_i && (!single_i || !lo_n_i);
	assign rw = b8_i ? {pat, mem[adr[11:0]]} : {mem[adr[11:0] | 12'h1], mem[adr[11:0] & 12'hffe]};
	assign wd = !mux_i ? dq_i : b8_i ? {8'h00, a_i[7:0]} : {dq_i[15:8], a_i[8], a_i[7:1]};
	assign din = rd_n_i ? {pat, pat} : rw;
	// Released pins never keep the last level
	assign dp_o = (doe_i & dq_i) | (~doe_i & (mux_i ? {din[15:8], pat} : din));
	assign lp_o = (aoe_i & a_i[7:0]) | (~aoe_i & (!mux_i ? pat : b8_i ? din[7:0] : {din[6:0], pat[0]}));
	assign mp_o = (moe_i & a_i[15:8]) | (~moe_i & (mux_i && !b8_i ? {pat[7:1], din[7]} : pat));
	assign rdy_n_o = !(slow_i && act && cnt < 3'h2);
	// Address capture, stores and wait count
	always_ff @(posedge mclk_i) begin
		pat <= pat + 8'h35;
		cnt <= act ? cnt + {2'h0, cnt != 3'h7} : 3'h0;
		if (ale_i)
			adr <= a_i;
		if (lo)
			mem[b8_i ? adr[11:0] : adr[11:0] & 12'hffe] <= wd[7:0];
		if (hi)
			mem[adr[11:0] | 12'h1] <= wd[15:8];
	end
endmodule : ebi_mem

// ==== sim/ebi_top_tb.sv ====
`timescale 1ns/1ps
module ebi_top_tb;
	logic        mclk_i = 1'b0, nrst_i = 1'b0, mux_en_i = 1'b0, strobe_single_i = 1'b0;
	logic        single_chip_i = 1'b0, bus_width_8_i = 1'b0, hold_n_i = 1'b1, rdy_n_i;
	logic        sub_osc_input_i = 1'b0, req_i = 1'b0, wr_i = 1'b0, word_i = 1'b0;
	logic        slow = 1'b0, wd, done_o, rd_n_o, ctl_oe_o, ale_o, bclk_o, clock_out_pin_o;
	logic        low_byte_store_strobe_n_o, high_byte_store_strobe_n_o, bus_release_ack_n_o;
	logic [1:0]  clk_sel_i = 2'h0;
	logic [19:0] addr_i = 20'h0, a;
	logic [15:0] wdata_i = 16'h0, d, rdata_o, dbus_o, dbus_oe_o, dbus_i;
	logic [7:0]  alo_o, alo_oe_o, alo_i, amid_o, amid_oe_o, amid_i;
	logic [3:0]  ahi_o, space_select_n_o;
	logic [7:0]  ref_mem [int];         // Reference byte memory
	int          err_total = 0, checks_done = 0, seed = 32'h388a, cyc, n;

	always #12.5 mclk_i = ~mclk_i;
	// Slow sub oscillator, 20 cycles per half period
	always begin
		repeat (20) @(posedge mclk_i);
		#2 sub_osc_input_i = ~sub_osc_input_i;
	end

	ebi_top dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .mux_en_i(mux_en_i),
		.strobe_single_i(strobe_single_i), .single_chip_i(single_chip_i), .clk_sel_i(clk_sel_i),
		.bus_width_8_i(bus_width_8_i), .hold_n_i(hold_n_i), .rdy_n_i(rdy_n_i),
		.sub_osc_input_i(sub_osc_input_i), .req_i(req_i), .wr_i(wr_i), .word_i(word_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .done_o(done_o), .rdata_o(rdata_o), .alo_o(alo_o),
		.alo_oe_o(alo_oe_o), .alo_i(alo_i), .amid_o(amid_o), .amid_oe_o(amid_oe_o),
		.amid_i(amid_i), .dbus_o(dbus_o), .dbus_oe_o(dbus_oe_o), .dbus_i(dbus_i), .ahi_o(ahi_o),
		.space_select_n_o(space_select_n_o), .low_byte_store_strobe_n_o(low_byte_store_strobe_n_o),
		.high_byte_store_strobe_n_o(high_byte_store_strobe_n_o), .rd_n_o(rd_n_o),
		.ctl_oe_o(ctl_oe_o), .ale_o(ale_o), .bclk_o(bclk_o),
		.bus_release_ack_n_o(bus_release_ack_n_o), .clock_out_pin_o(clock_out_pin_o));

	ebi_mem mem (.mclk_i(mclk_i), .mux_i(mux_en_i), .b8_i(bus_width_8_i),
		.single_i(strobe_single_i), .slow_i(slow), .ale_i(ale_o), .a_i({ahi_o, amid_o, alo_o}),
		.dq_i(dbus_o), .aoe_i(alo_oe_o), .moe_i(amid_oe_o), .doe_i(dbus_oe_o),
		.lo_n_i(low_byte_store_strobe_n_o), .hi_n_i(high_byte_store_strobe_n_o),
		.rd_n_i(rd_n_o), .lp_o(alo_i), .mp_o(amid_i), .dp_o(dbus_i), .rdy_n_o(rdy_n_i));

	task chk(input string what, input logic [39:0] exp, input logic [39:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task give_verdict;
		$display("comparisons %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	// One access, pins checked each cycle, result against the reference
	task automatic acc(input logic w, input logic wrd, input logic [19:0] ad, input logic [15:0] dt);
		logic [19:0] li, hi;
		logic [15:0] m;
		logic        el, eh, bk;
		li = bus_width_8_i ? ad : {ad[19:1], 1'b0};
		hi = {ad[19:1], 1'b1};
		m = bus_width_8_i ? 16'h00ff : wrd ? 16'hffff : ad[0] ? 16'hff00 : 16'h00ff;
		el = strobe_single_i ? !w : !(w && m[0]);
		eh = strobe_single_i ? !(ad[0] || (wrd && !bus_width_8_i)) : !(w && m[8]);
		@(posedge mclk_i);
		#2;
		req_i = 1'b1;
		wr_i = w;
		word_i = wrd;
		addr_i = ad;
		wdata_i = dt;
		cyc = 0;
		while (done_o !== 1'b1 && cyc < 40) begin
			bk = bclk_o;
			@(posedge mclk_i);
			#2;
			cyc++;
			// Bus clock toggles on every rising main clock edge
			chk("bclk", !bk, bclk_o);
			if (ale_o === 1'b1) begin
				chk("addr", ad, {ahi_o, amid_o, alo_o});
				chk("sel", 4'(~(4'h1 << ad[19:18])), space_select_n_o);
			end
			if (cyc > 2 && done_o !== 1'b1) begin
				chk("strobes", {w, el, eh},
					{rd_n_o, low_byte_store_strobe_n_o, high_byte_store_strobe_n_o});
				if (w && mux_en_i && bus_width_8_i)
					chk("mux8", dt[7:0], alo_o);
				if (w && mux_en_i && !bus_width_8_i)
					chk("mux16", {ad[15:9], ad[0], dt & m},
						{amid_o[7:1], alo_o[0], {dbus_o[15:8], amid_o[0], alo_o[7:1]} & m});
				if (!mux_en_i)
					chk("amid", ad[15:8], amid_o);
			end
		end
		req_i = 1'b0;
		if (slow)
			chk("stretch", 1, cyc > 6);
		else
			// Address cycle, three strobe cycles, then the done cycle
			chk("latency", 5, cyc);
		if (w) begin
			if (m[0])
				ref_mem[li] = dt[7:0];
			if (m[8])
				ref_mem[hi] = dt[15:8];
		end else
			chk("rdata", {m[8] ? ref_mem[hi] : 8'h00, m[0] ? ref_mem[li] : 8'h00},
				rdata_o & m);
	endtask : acc

	// Cycles until the clock pin changes
	task tgl;
		logic v;
		v = clock_out_pin_o;
		n = 0;
		while (clock_out_pin_o === v && n < 100) begin
			@(posedge mclk_i);
			#2;
			n++;
		end
	endtask : tgl

	initial begin
		#(25 * 20000);
		err_total++;
		$display("watchdog expired");
		give_verdict();
	end

	initial begin
		repeat (12) @(posedge mclk_i);
		#2 nrst_i = 1'b1;
		// Every bus layout and strobe scheme, random traffic
		for (int c = 0; c < 8; c++) begin
			@(posedge mclk_i);
			#2;
			mux_en_i = c[0];
			bus_width_8_i = c[1];
			strobe_single_i = c[2];
			repeat (4) @(posedge mclk_i);
			for (int k = 0; k < 12; k++) begin
				a = $random(seed);
				d = $random(seed);
				wd = $random(seed);
				slow = ($random(seed) % 3) == 0;
				if (wd && !bus_width_8_i)
					a[0] = 1'b0;
				acc(1'b1, wd, a, d);
				acc(1'b0, wd, a, d);
			end
			$display("layout %0d finished, mismatches %0d", c, err_total);
		end
		// Bus release while a request waits
		hold_n_i = 1'b0;
		repeat (5) @(posedge mclk_i);
		#2;
		chk("release", 34'h0, {bus_release_ack_n_o, ctl_oe_o, alo_oe_o, amid_oe_o, dbus_oe_o});
		req_i = 1'b1;
		wr_i = 1'b0;
		repeat (8) begin
			@(posedge mclk_i);
			#2;
			chk("held", 2'h0, {done_o, bus_release_ack_n_o});
		end
		hold_n_i = 1'b1;
		cyc = 0;
		while (done_o !== 1'b1 && cyc < 20) begin
			@(posedge mclk_i);
			#2;
			cyc++;
		end
		req_i = 1'b0;
		chk("resume", 2'h3, {done_o, bus_release_ack_n_o});
		$display("bus release finished, mismatches %0d", err_total);
		// Clock pin rates
		chk("clock pin off", 1'b0, clock_out_pin_o);
		single_chip_i = 1'b1;
		// Selection 3 keeps the pin low, so the wait runs out at 100
		for (int s = 0; s < 4; s++) begin
			clk_sel_i = s[1:0];
			tgl();
			tgl();
			tgl();
			chk("clock pin", s == 0 ? 4 : s == 1 ? 16 : s == 2 ? 20 : 100, n);
		end
		$display("clock pin finished, mismatches %0d", err_total);
		give_verdict();
	end
endmodule : ebi_top_tb
